// >>> verilog/uds_pkg.sv
// Shared constants, types and helpers of the serial data and status block
package uds_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam int         DIV_W        = 12;
	localparam logic [7:0] OFS_DATA     = 8'h00;
	localparam logic [7:0] OFS_STATUS_A = 8'h04;
	localparam logic [7:0] OFS_CTRL_B   = 8'h08;
	localparam logic [7:0] OFS_FRAME    = 8'h0c;
	localparam logic [7:0] OFS_DIVISOR  = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int STA_RXC   = 7;
	localparam int STA_TXC   = 6;
	localparam int STA_UDRE  = 5;
	localparam int STA_FE    = 4;
	localparam int STA_DOR   = 3;
	localparam int STA_PE    = 2;
	localparam int STA_U2X   = 1;
	localparam int STA_MPCM  = 0;
	localparam int CTB_RXCIE = 7;
	localparam int CTB_RXEN  = 4;
	localparam int CTB_TXEN  = 3;
	localparam int FRM_PAR   = 4;
	localparam int FRM_STOP  = 3;
	localparam int FRM_SIZE  = 1;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0]       RST_STATUS_A = 8'h20;
	localparam logic [7:0]       RST_CTRL_B   = 8'h00;
	localparam logic [7:0]       RST_FRAME    = 8'h06;
	localparam logic [DIV_W-1:0] RST_DIVISOR  = 12'h000;
	localparam int               OSR_NORMAL   = 16;
	localparam int               OSR_DOUBLE   = 8;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] charSize;
		logic       twoStop;
		logic [1:0] parMode;
		logic       dblSpeed;
	} uds_frame_cfg_t;

	typedef struct packed {
		logic [7:0] data;
		logic       frameErr;
		logic       parityErr;
		logic       addrBit;
	} uds_rx_char_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] uds_mask(input logic [7:0] d, input logic [1:0] size);
		return d & (8'hff >> (2'd3 - size));
	endfunction

	function automatic logic uds_parity(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction

	function automatic logic [3:0] uds_last_tick(input logic dbl);
		return dbl ? 4'(OSR_DOUBLE - 1) : 4'(OSR_NORMAL - 1);
	endfunction

	function automatic logic [2:0] uds_last_bit(input logic [1:0] size);
		return 3'd4 + {1'b0, size};
	endfunction

endpackage

// >>> verilog/uds_tx_shift.sv
// Transmit shift register and frame sequencer
`timescale 1ns/100ps
module uds_tx_shift import uds_pkg::*; (
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire logic     sampleTick,
	input  uds_frame_cfg_t cfg,
	input  wire logic     load,
	input  wire logic [7:0] data,
	output logic          line,
	output logic          busy,
	output logic          done
);
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_PAR   = 5'b01000,
		TX_STOP  = 5'b10000
	} uds_tx_state_t;

	typedef struct packed {
		uds_tx_state_t state;
		logic [7:0]    shift;
		logic [2:0]    bitCnt;
		logic [3:0]    tickCnt;
		logic          par;
		logic          stopLeft;
		logic          line;
		logic          done;
	} uds_tx_reg_t;

	uds_tx_reg_t s_r;
	uds_tx_reg_t s_nxt;
	logic        bitEdge;

	assign bitEdge = sampleTick && s_r.tickCnt == uds_last_tick(cfg.dblSpeed);
	assign line    = s_r.line;
	assign busy    = s_r.state != TX_IDLE;
	assign done    = s_r.done;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (sampleTick && s_r.state != TX_IDLE) begin
			s_nxt.tickCnt = bitEdge ? 4'd0 : s_r.tickCnt + 4'd1;
		end
		case (s_r.state)
			TX_IDLE: begin
				s_nxt.line = 1'b1;
				if (load) begin
					s_nxt.state   = TX_START;
					s_nxt.shift   = uds_mask(data, cfg.charSize);
					s_nxt.par     = uds_parity(uds_mask(data, cfg.charSize), cfg.parMode[0]);
					s_nxt.tickCnt = 4'd0;
					s_nxt.line    = 1'b0;
				end
			end
			TX_START: if (bitEdge) begin
				s_nxt.state  = TX_DATA;
				s_nxt.line   = s_r.shift[0];
				s_nxt.shift  = s_r.shift >> 1;
				s_nxt.bitCnt = 3'd0;
			end
			TX_DATA: if (bitEdge) begin
				if (s_r.bitCnt != uds_last_bit(cfg.charSize)) begin
					s_nxt.bitCnt = s_r.bitCnt + 3'd1;
					s_nxt.line   = s_r.shift[0];
					s_nxt.shift  = s_r.shift >> 1;
				end else if (cfg.parMode[1]) begin
					s_nxt.state = TX_PAR;
					s_nxt.line  = s_r.par;
				end else begin
					s_nxt.state    = TX_STOP;
					s_nxt.line     = 1'b1;
					s_nxt.stopLeft = cfg.twoStop;
				end
			end
			TX_PAR: if (bitEdge) begin
				s_nxt.state    = TX_STOP;
				s_nxt.line     = 1'b1;
				s_nxt.stopLeft = cfg.twoStop;
			end
			TX_STOP: if (bitEdge) begin
				if (s_r.stopLeft) begin
					s_nxt.stopLeft = 1'b0;
				end else begin
					s_nxt.state = TX_IDLE;
					s_nxt.done  = 1'b1;
				end
			end
			default: s_nxt.state = TX_IDLE;
		endcase
		if (rst) begin
			s_nxt       = '0;
			s_nxt.state = TX_IDLE;
			s_nxt.line  = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	property p_txBitLen;
		@(posedge clk) disable iff (rst)
		(s_r.state != TX_IDLE && cfg.dblSpeed) |-> s_r.tickCnt < 4'd8;
	endproperty
	a_txBitLen: assert property (p_txBitLen) else $error("bit period exceeds double speed");

endmodule // uds_tx_shift

// >>> verilog/uds_rx_shift.sv
// Receive sampler and shift register, oversampled at mid-bit
`timescale 1ns/100ps
module uds_rx_shift import uds_pkg::*; (
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      enable,
	input  wire logic      sampleTick,
	input  uds_frame_cfg_t cfg,
	input  wire logic      rxLine,
	output logic           startSeen,
	output logic           done,
	output uds_rx_char_t   ch
);
	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_PAR   = 5'b01000,
		RX_STOP  = 5'b10000
	} uds_rx_state_t;

	typedef struct packed {
		uds_rx_state_t state;
		logic [3:0]    tickCnt;
		logic [2:0]    bitCnt;
		logic [7:0]    shift;
		logic          parErr;
		uds_rx_char_t  ch;
		logic          done;
		logic          startSeen;
	} uds_rx_reg_t;

	uds_rx_reg_t s_r;
	uds_rx_reg_t s_nxt;
	logic        bitEdge;

	assign bitEdge   = sampleTick && s_r.tickCnt == uds_last_tick(cfg.dblSpeed);
	assign startSeen = s_r.startSeen;
	assign done      = s_r.done;
	assign ch        = s_r.ch;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done      = 1'b0;
		s_nxt.startSeen = 1'b0;
		if (sampleTick) begin
			s_nxt.tickCnt = bitEdge ? 4'd0 : s_r.tickCnt + 4'd1;
		end
		case (s_r.state)
			RX_IDLE: if (sampleTick && !rxLine) begin
				s_nxt.state     = RX_START;
				s_nxt.tickCnt   = 4'd0;
				s_nxt.startSeen = 1'b1;
			end
			// Recheck at mid start bit rejects glitches
			RX_START: if (sampleTick && s_r.tickCnt == (uds_last_tick(cfg.dblSpeed) >> 1)) begin
				s_nxt.tickCnt = 4'd0;
				s_nxt.state   = rxLine ? RX_IDLE : RX_DATA;
				s_nxt.bitCnt  = 3'd0;
				s_nxt.shift   = 8'h00;
				s_nxt.parErr  = 1'b0;
			end
			RX_DATA: if (bitEdge) begin
				s_nxt.shift[s_r.bitCnt] = rxLine;
				if (s_r.bitCnt == uds_last_bit(cfg.charSize)) begin
					s_nxt.state = cfg.parMode[1] ? RX_PAR : RX_STOP;
				end else begin
					s_nxt.bitCnt = s_r.bitCnt + 3'd1;
				end
			end
			RX_PAR: if (bitEdge) begin
				s_nxt.parErr = uds_parity(s_r.shift, cfg.parMode[0]) != rxLine;
				s_nxt.state  = RX_STOP;
			end
			RX_STOP: if (bitEdge) begin
				s_nxt.state        = RX_IDLE;
				s_nxt.done         = 1'b1;
				s_nxt.ch.data      = s_r.shift;
				s_nxt.ch.frameErr  = !rxLine;
				s_nxt.ch.parityErr = s_r.parErr;
				s_nxt.ch.addrBit   = rxLine;
			end
			default: s_nxt.state = RX_IDLE;
		endcase
		if (rst || !enable) begin
			s_nxt       = '0;
			s_nxt.state = RX_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	property p_rxFrameErr;
		@(posedge clk) disable iff (rst)
		(s_r.state == RX_STOP && bitEdge && enable)
			|=> s_r.done && s_r.ch.frameErr == !$past(rxLine);
	endproperty
	a_rxFrameErr: assert property (p_rxFrameErr) else $error("frame error not tied to stop bit");

endmodule // uds_rx_shift

// >>> verilog/uds_top.sv
// Serial data port, status flags and control registers behind an APB slave
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
// ----------------------------------------------------------------
module uds_top import uds_pkg::*; (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              globalIrqEnable,
	input  wire logic              txcIrqAck,
	input  wire logic              rxLine,
	output logic                   txLine,
	output logic                   txLineOe,
	output logic                   rxIrq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                rxcIe;
		logic                rxEn;
		logic                txEn;
		logic                txActive;
		logic                mpcm;
		uds_frame_cfg_t      cfg;
		logic [DIV_W-1:0]    divisor;
		logic [DIV_W-1:0]    baudCnt;
		logic                sampleTick;
		logic [7:0]          transmit_holding_buffer;
		logic                txbFull;
		logic                txc;
		logic                dor;
		uds_rx_char_t [1:0]  fifo;
		logic [1:0]          cnt;
		uds_rx_char_t        pend;
		logic                pendValid;
		logic                popArm;
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
		logic                rxIrq;
	} uds_top_reg_t;

	uds_top_reg_t s_r;
	uds_top_reg_t s_nxt;
	logic         setupPh;
	logic         accessPh;
	logic         popNow;
	logic         txLoad;
	logic         txBusy;
	logic         txDone;
	logic         rxStart;
	logic         rxDone;
	logic         rxAccept;
	uds_rx_char_t rxCh;

	function automatic logic regHit(input logic [ADDR_W-1:0] a);
		return a == OFS_DATA || a == OFS_STATUS_A || a == OFS_CTRL_B ||
			a == OFS_FRAME || a == OFS_DIVISOR;
	endfunction

	function automatic uds_frame_cfg_t frameOf(input logic [7:0] v, input logic dbl);
		uds_frame_cfg_t f;
		f.charSize = v[FRM_SIZE +: 2];
		f.twoStop  = v[FRM_STOP];
		f.parMode  = v[FRM_PAR +: 2];
		f.dblSpeed = dbl;
		return f;
	endfunction

	function automatic logic [7:0] statusOf(input uds_top_reg_t st);
		logic [7:0] v;
		v            = 8'h00;
		v[STA_RXC]   = st.cnt != 2'd0;
		v[STA_TXC]   = st.txc;
		v[STA_UDRE]  = !st.txbFull;
		v[STA_FE]    = st.cnt != 2'd0 && st.fifo[0].frameErr;
		v[STA_DOR]   = st.dor;
		v[STA_PE]    = st.cnt != 2'd0 && st.fifo[0].parityErr;
		v[STA_U2X]   = st.cfg.dblSpeed;
		v[STA_MPCM]  = st.mpcm;
		return v;
	endfunction

	// ------------------------------------------------------------
	// Serial engines
	// ------------------------------------------------------------
	uds_tx_shift u_tx (
		.clk        (clk),
		.rst        (rst),
		.sampleTick (s_r.sampleTick),
		.cfg        (s_r.cfg),
		.load       (txLoad),
		.data       (s_r.transmit_holding_buffer),
		.line       (txLine),
		.busy       (txBusy),
		.done       (txDone)
	);

	uds_rx_shift u_rx (
		.clk        (clk),
		.rst        (rst),
		.enable     (s_r.rxEn),
		.sampleTick (s_r.sampleTick),
		.cfg        (s_r.cfg),
		.rxLine     (rxLine),
		.startSeen  (rxStart),
		.done       (rxDone),
		.ch         (rxCh)
	);

	assign setupPh  = psel && !penable;
	assign accessPh = psel && penable && s_r.pready;
	assign popNow   = accessPh && !pwrite && s_r.popArm;
	assign txLoad   = s_r.txActive && s_r.txbFull && !txBusy;
	assign rxAccept = rxDone && !(s_r.mpcm && !rxCh.addrBit);

	assign prdata   = s_r.prdata;
	assign pready   = s_r.pready;
	assign pslverr  = s_r.pslverr;
	assign txLineOe = s_r.txActive;
	assign rxIrq    = s_r.rxIrq;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.pready     = 1'b0;
		s_nxt.pslverr    = 1'b0;
		s_nxt.popArm     = 1'b0;
		s_nxt.sampleTick = 1'b0;

		// Oversampling tick every divisor+1 clocks
		if (s_r.baudCnt == '0) begin
			s_nxt.baudCnt    = s_r.divisor;
			s_nxt.sampleTick = 1'b1;
		end else begin
			s_nxt.baudCnt = s_r.baudCnt - 1'b1;
		end

		// Read data is captured in setup so the access phase needs no wait
		if (setupPh) begin
			s_nxt.pready  = 1'b1;
			s_nxt.pslverr = !regHit(paddr);
			s_nxt.prdata  = 32'h0000_0000;
			if (!pwrite) begin
				case (paddr)
					OFS_DATA: begin
						s_nxt.prdata[7:0] = s_r.cnt != 2'd0 ? s_r.fifo[0].data : 8'h00;
						s_nxt.popArm      = s_r.cnt != 2'd0;
					end
					OFS_STATUS_A: s_nxt.prdata[7:0] = statusOf(s_r);
					OFS_CTRL_B: begin
						s_nxt.prdata[CTB_RXCIE] = s_r.rxcIe;
						s_nxt.prdata[CTB_RXEN]  = s_r.rxEn;
						s_nxt.prdata[CTB_TXEN]  = s_r.txEn;
					end
					OFS_FRAME: begin
						s_nxt.prdata[FRM_SIZE +: 2] = s_r.cfg.charSize;
						s_nxt.prdata[FRM_STOP]      = s_r.cfg.twoStop;
						s_nxt.prdata[FRM_PAR +: 2]  = s_r.cfg.parMode;
					end
					OFS_DIVISOR: s_nxt.prdata[DIV_W-1:0] = s_r.divisor;
					default: s_nxt.prdata = 32'h0000_0000;
				endcase
			end
		end

		if (txcIrqAck) begin
			s_nxt.txc = 1'b0;
		end

		if (accessPh && pwrite) begin
			case (paddr)
				OFS_DATA: if (!s_r.txbFull) begin
					s_nxt.transmit_holding_buffer     = pwdata[7:0];
					s_nxt.txbFull = 1'b1;
				end
				OFS_STATUS_A: begin
					if (pwdata[STA_TXC]) begin
						s_nxt.txc = 1'b0;
					end
					s_nxt.cfg.dblSpeed = pwdata[STA_U2X];
					s_nxt.mpcm         = pwdata[STA_MPCM];
				end
				OFS_CTRL_B: begin
					s_nxt.rxcIe = pwdata[CTB_RXCIE];
					s_nxt.rxEn  = pwdata[CTB_RXEN];
					s_nxt.txEn  = pwdata[CTB_TXEN];
				end
				OFS_FRAME: s_nxt.cfg = frameOf(pwdata[7:0], s_r.cfg.dblSpeed);
				OFS_DIVISOR: begin
					s_nxt.divisor = pwdata[DIV_W-1:0];
					s_nxt.baudCnt = pwdata[DIV_W-1:0];
				end
				default: ;
			endcase
		end

		// Transmit side; completion set wins over a same-cycle clear
		if (txLoad) begin
			s_nxt.txbFull = 1'b0;
		end
		if (txDone && !s_r.txbFull) begin
			s_nxt.txc = 1'b1;
		end
		// Old buffer state keeps the line owned across the load cycle
		s_nxt.txActive = s_r.txEn ||
			(s_r.txActive && (txBusy || s_r.txbFull || s_nxt.txbFull));

		// Receive FIFO: pop, then refill from the waiting character, then push
		if (popNow && s_r.cnt != 2'd0) begin
			s_nxt.fifo[0] = s_r.fifo[1];
			s_nxt.cnt     = s_r.cnt - 2'd1;
			s_nxt.dor     = 1'b0;
		end
		if (s_r.pendValid && s_nxt.cnt != 2'd2) begin
			s_nxt.fifo[s_nxt.cnt[0]] = s_r.pend;
			s_nxt.cnt                = s_nxt.cnt + 2'd1;
			s_nxt.pendValid          = 1'b0;
		end
		if (rxAccept) begin
			if (s_nxt.cnt != 2'd2) begin
				s_nxt.fifo[s_nxt.cnt[0]] = rxCh;
				s_nxt.cnt                = s_nxt.cnt + 2'd1;
			end else if (!s_nxt.pendValid) begin
				s_nxt.pend      = rxCh;
				s_nxt.pendValid = 1'b1;
			end
		end
		if (rxStart && s_r.cnt == 2'd2 && s_r.pendValid) begin
			s_nxt.dor = 1'b1;
		end
		if (!s_r.rxEn) begin
			s_nxt.cnt       = 2'd0;
			s_nxt.pendValid = 1'b0;
			s_nxt.dor       = 1'b0;
		end

		s_nxt.rxIrq = s_r.rxcIe && globalIrqEnable && s_r.cnt != 2'd0;

		if (rst) begin
			s_nxt              = '0;
			s_nxt.cfg          = frameOf(RST_FRAME, RST_STATUS_A[STA_U2X]);
			s_nxt.mpcm         = RST_STATUS_A[STA_MPCM];
			s_nxt.txbFull      = !RST_STATUS_A[STA_UDRE];
			s_nxt.rxcIe        = RST_CTRL_B[CTB_RXCIE];
			s_nxt.rxEn         = RST_CTRL_B[CTB_RXEN];
			s_nxt.txEn         = RST_CTRL_B[CTB_TXEN];
			s_nxt.divisor      = RST_DIVISOR;
			s_nxt.baudCnt      = RST_DIVISOR;
		end
	end

	always_ff @(posedge clk) begin
		s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_dropWhenFull;
		(accessPh && pwrite && paddr == OFS_DATA && s_r.txbFull) |=> s_r.transmit_holding_buffer == $past(s_r.transmit_holding_buffer);
	endproperty
	a_dropWhenFull: assert property (p_dropWhenFull) else $error("write to full buffer changed it");

	property p_loadToShift;
		txLoad |=> txBusy && !s_r.txbFull;
	endproperty
	a_loadToShift: assert property (p_loadToShift) else $error("buffer not moved to shifter");

	property p_popOne;
		(popNow && s_r.cnt != 2'd0 && !rxDone && !s_r.pendValid && s_r.rxEn)
			|=> s_r.cnt == $past(s_r.cnt) - 2'd1;
	endproperty
	a_popOne: assert property (p_popOne) else $error("data read did not pop one entry");

	property p_rxcRead;
		(setupPh && !pwrite && paddr == OFS_STATUS_A)
			|=> prdata[STA_RXC] == ($past(s_r.cnt) != 2'd0);
	endproperty
	a_rxcRead: assert property (p_rxcRead) else $error("receive-complete flag wrong");

	property p_flushOnDisable;
		!s_r.rxEn |=> s_r.cnt == 2'd0
			##1 (!prdata[STA_RXC] || !pready || !$past(paddr == OFS_STATUS_A));
	endproperty
	a_flushOnDisable: assert property (p_flushOnDisable) else $error("FIFO not flushed");

	property p_txcSet;
		(txDone && !s_r.txbFull) |=> s_r.txc;
	endproperty
	a_txcSet: assert property (p_txcSet) else $error("transmit-complete not set");

	property p_txcAck;
		(txcIrqAck && !(txDone && !s_r.txbFull)) |=> !s_r.txc;
	endproperty
	a_txcAck: assert property (p_txcAck) else $error("transmit-complete not cleared");

	property p_udreAfterReset;
		$fell(rst) |-> !s_r.txbFull && !txBusy;
	endproperty
	a_udreAfterReset: assert property (p_udreAfterReset) else $error("buffer not empty after reset");

	property p_overrun;
		(rxStart && s_r.cnt == 2'd2 && s_r.pendValid && s_r.rxEn) |=> s_r.dor;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_mpcmDrop;
		(rxDone && s_r.mpcm && !rxCh.addrBit && !popNow && !s_r.pendValid)
			|=> $stable(s_r.cnt);
	endproperty
	a_mpcmDrop: assert property (p_mpcmDrop) else $error("non-address frame stored");

	property p_rxIrq;
		rxIrq |-> $past(s_r.rxcIe && globalIrqEnable && s_r.cnt != 2'd0);
	endproperty
	a_rxIrq: assert property (p_rxIrq) else $error("receive interrupt without cause");

	property p_txDefer;
		(!s_r.txEn && s_r.txActive && (txBusy || s_r.txbFull)) |=> s_r.txActive;
	endproperty
	a_txDefer: assert property (p_txDefer) else $error("transmitter released early");

	property p_errFlush;
		!s_r.rxEn |=> !s_r.dor && !s_r.pendValid;
	endproperty
	a_errFlush: assert property (p_errFlush) else $error("error flags kept after disable");

	c_txFrame: cover property (txDone && !s_r.txbFull);
	c_rxChar: cover property (rxAccept);
	c_overrun: cover property ($rose(s_r.dor));
	c_popFull: cover property (popNow && s_r.cnt == 2'd2);

endmodule // uds_top

// >>> tb/uds_peer.sv
// Remote serial peer: drives the receive line, captures the transmit line
`timescale 1ns/100ps
module uds_peer (
	input  wire logic clk,
	input  wire logic txLine,
	output logic      rxLine
);
	logic [7:0] got;
	int         bitClks = 16;

	initial rxLine = 1'b1;

	// ----
	// Frames at divisor 0: bitClks clocks a bit, LSB first
	// ----
	task automatic send(input logic [7:0] d, input logic stopBit, input int n);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		f[n + 1] = stopBit;
		for (int i = 0; i < n + 2; i++) begin
			rxLine <= f[i];
			repeat (bitClks) @(posedge clk);
		end
		// Idle gap so the next start edge is seen
		rxLine <= 1'b1;
		repeat (bitClks) @(posedge clk);
	endtask

	task automatic capture();
		@(negedge txLine);
		repeat (bitClks / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bitClks) @(posedge clk);
			got[i] = txLine;
		end
	endtask
endmodule // uds_peer

// >>> tb/uart_data_status_flags_bench.sv
// Self-checking bench of the serial data port and status flags
`timescale 1ns/100ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module uart_data_status_flags_bench import uds_pkg::*; ();
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata, rd;
	logic              pready, pslverr, se, rxLine, txLine, txLineOe, rxIrq;
	logic              gie = 1'b0;
	logic              ack = 1'b0;
	int                errors = 0;
	int                testsRun = 0;
	int                cyc = 0;

	always #2.5 clk = ~clk;

	uds_top u_uds_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .globalIrqEnable(gie), .txcIrqAck(ack),
		.rxLine(rxLine), .txLine(txLine), .txLineOe(txLineOe), .rxIrq(rxIrq));
	uds_peer u_uds_peer (.clk(clk), .txLine(txLine), .rxLine(rxLine));

	// ----
	// Bus access
	// ----
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic chk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		chk("status", OFS_STATUS_A, 32'h20);
		chk("control", OFS_CTRL_B, 32'h00);
		apb(1'b0, 8'h40, 32'h0);
		`CHK("slverr", 1'b1, se)
		$display("test reset done");
	endtask

	task automatic t_tx();
		apb(1'b1, OFS_CTRL_B, 32'h08);
		fork
			u_uds_peer.capture();
			apb(1'b1, OFS_DATA, 32'ha5);
		join
		`CHK("tx char", 8'ha5, u_uds_peer.got)
		repeat (40) @(posedge clk);
		chk("status", OFS_STATUS_A, 32'h60);
		apb(1'b1, OFS_STATUS_A, 32'h40);
		chk("status", OFS_STATUS_A, 32'h20);
		// Disabled transmitter holds the buffer, so the second write is dropped
		apb(1'b1, OFS_CTRL_B, 32'h00);
		apb(1'b1, OFS_DATA, 32'h11);
		apb(1'b1, OFS_DATA, 32'h22);
		chk("status", OFS_STATUS_A, 32'h00);
		fork
			u_uds_peer.capture();
			apb(1'b1, OFS_CTRL_B, 32'h08);
		join
		`CHK("held char", 8'h11, u_uds_peer.got)
		repeat (40) @(posedge clk);
		chk("status", OFS_STATUS_A, 32'h60);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		@(posedge clk);
		chk("status", OFS_STATUS_A, 32'h20);
		$display("test transmit done");
	endtask

	task automatic t_rx();
		gie <= 1'b1;
		apb(1'b1, OFS_CTRL_B, 32'h90);
		u_uds_peer.send(8'h3c, 1'b0, 8);
		u_uds_peer.send(8'h5a, 1'b1, 8);
		`CHK("irq", 1'b1, rxIrq)
		chk("status", OFS_STATUS_A, 32'hb0);
		chk("data", OFS_DATA, 32'h3c);
		chk("status", OFS_STATUS_A, 32'ha0);
		apb(1'b1, OFS_CTRL_B, 32'h80);
		chk("status", OFS_STATUS_A, 32'h20);
		repeat (2) @(posedge clk);
		`CHK("irq", 1'b0, rxIrq)
		$display("test receive done");
	endtask

	task automatic t_short();
		apb(1'b1, OFS_FRAME, 32'h02);
		apb(1'b1, OFS_CTRL_B, 32'h10);
		apb(1'b1, OFS_STATUS_A, 32'h01);
		u_uds_peer.send(8'hff, 1'b0, 6);
		chk("status", OFS_STATUS_A, 32'h21);
		u_uds_peer.send(8'hff, 1'b1, 6);
		chk("data", OFS_DATA, 32'h3f);
		$display("test short character done");
	endtask

	task automatic t_fast();
		u_uds_peer.bitClks = 8;
		apb(1'b1, OFS_FRAME, 32'h24);
		apb(1'b1, OFS_STATUS_A, 32'h02);
		apb(1'b1, OFS_CTRL_B, 32'h18);
		fork
			u_uds_peer.capture();
			begin
				apb(1'b1, OFS_DATA, 32'h85);
				apb(1'b1, OFS_CTRL_B, 32'h10);
			end
		join
		// Seven data bits then the even parity bit
		`CHK("tx fast", 8'h05, u_uds_peer.got)
		`CHK("oe held", 1'b1, txLineOe)
		repeat (40) @(posedge clk);
		`CHK("oe free", 1'b0, txLineOe)
		chk("status", OFS_STATUS_A, 32'h62);
		apb(1'b1, OFS_STATUS_A, 32'h42);
		// Top bit of each byte lands in the parity slot
		u_uds_peer.send(8'h83, 1'b1, 8);
		u_uds_peer.send(8'h41, 1'b1, 8);
		u_uds_peer.send(8'h05, 1'b1, 8);
		u_uds_peer.send(8'h7f, 1'b1, 8);
		chk("status", OFS_STATUS_A, 32'hae);
		chk("data", OFS_DATA, 32'h03);
		chk("status", OFS_STATUS_A, 32'ha2);
		chk("data", OFS_DATA, 32'h41);
		chk("data", OFS_DATA, 32'h05);
		chk("status", OFS_STATUS_A, 32'h22);
		apb(1'b1, OFS_DATA, 32'h11);
		chk("status", OFS_STATUS_A, 32'h02);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("status", OFS_STATUS_A, 32'h20);
		u_uds_peer.bitClks = 16;
		$display("test fast frames done");
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Ceiling well above the fewer than two thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_tx();
		t_rx();
		t_short();
		t_fast();
		print_verdict();
	end
endmodule // uart_data_status_flags_bench
